/* File: rtl/amdu_core.sv */
// Multiply/divide unit: multiply pipeline, accumulator pairs, divider
`timescale 1ns/1ps
module amdu_core
  import amdu_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic req_valid_in,
  input wire amdu_req_s req_in,
  output logic stall_out,
  output logic div_busy_out,
  output amdu_res_s res_out
);

  amdu_stage_s stage [AMDU_MUL_LAT];
  amdu_stage_s issue_entry;
  logic [AMDU_ACC_W-1:0] acc [AMDU_PAIRS];
  logic accept;
  logic div_busy;
  logic div_done;
  logic div_start;
  logic [AMDU_W-1:0] div_quot;
  logic [AMDU_W-1:0] div_rem;
  logic [AMDU_PAIR_W-1:0] div_acc_sel;
  logic signed [AMDU_W:0] fact_a;
  logic signed [AMDU_W:0] fact_b;
  logic signed [2*AMDU_W+1:0] product;
  logic signed [AMDU_W-1:0] dot_hi;
  logic signed [AMDU_W-1:0] dot_lo;
  logic signed [AMDU_W:0] dot_sum;
  logic [AMDU_ACC_W-1:0] acc_cur;
  logic [AMDU_ACC_W:0] acc_sum;
  logic [AMDU_ACC_W-1:0] next_acc;
  logic acc_wr;
  logic [5:0] shift_left;
  amdu_stage_s tail;

  // any issue while a divide runs is held off
  assign stall_out = req_valid_in & div_busy;
  assign accept = req_valid_in & ~div_busy;
  assign div_start = accept && (req_in.op == AMDU_OP_ITERATIVE_DIVIDE);
  assign div_busy_out = div_busy;

  // signed or zero-extended 33-bit factors, first times second
  always_comb begin
    fact_a = $signed({req_in.is_signed & req_in.first_source_operand[AMDU_W-1],
                      req_in.first_source_operand});
    fact_b = $signed({req_in.is_signed & req_in.second_source_operand[AMDU_W-1],
                      req_in.second_source_operand});
    product = fact_a * fact_b;
    // paired halfword products for the signal-processing forms
    dot_hi = $signed(req_in.first_source_operand[31:16])
           * $signed(req_in.second_source_operand[31:16]);
    dot_lo = $signed(req_in.first_source_operand[15:0])
           * $signed(req_in.second_source_operand[15:0]);
    dot_sum = {dot_hi[AMDU_W-1], dot_hi} + {dot_lo[AMDU_W-1], dot_lo};
  end

  // Entry formed at issue; operands reduce to one 64-bit term
  always_comb begin
    issue_entry.valid = accept && (req_in.op != AMDU_OP_ITERATIVE_DIVIDE)
                        && (req_in.op != AMDU_OP_NONE);
    issue_entry.op = req_in.op;
    issue_entry.saturate = req_in.saturate;
    issue_entry.acc_sel = req_in.acc_sel;
    issue_entry.dest = req_in.dest;
    issue_entry.shamt = req_in.second_source_operand[5:0];
    case (req_in.op)
      AMDU_OP_DPA, AMDU_OP_DPS, AMDU_OP_DMUL: begin
        issue_entry.term = {{(AMDU_ACC_W-AMDU_W-1){dot_sum[AMDU_W]}}, dot_sum};
      end
      default: begin
        issue_entry.term = product[AMDU_ACC_W-1:0];
      end
    endcase
  end

  // pipeline advances every clock, with no stall input at all
  // a new entry may enter on every clock
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < AMDU_MUL_LAT; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= issue_entry;
      for (int i = 1; i < AMDU_MUL_LAT; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign tail = stage[AMDU_MUL_LAT-1];
  assign acc_cur = acc[tail.acc_sel];
  assign shift_left = 6'h0 - tail.shamt;

  // Commit arithmetic from the last stage
  always_comb begin
    next_acc = acc_cur;
    acc_wr = 1'b0;
    acc_sum = '0;
    case (tail.op)
      AMDU_OP_ACC_MULTIPLY, AMDU_OP_DMUL: begin
        next_acc = tail.term;
        acc_wr = tail.valid;
      end
      // accumulate product into the pair, or take it away
      AMDU_OP_ACC_MULTIPLY_ADD, AMDU_OP_DPA: begin
        acc_sum = {acc_cur[AMDU_ACC_W-1], acc_cur} + {tail.term[AMDU_ACC_W-1], tail.term};
        next_acc = acc_sum[AMDU_ACC_W-1:0];
        acc_wr = tail.valid;
      end
      AMDU_OP_ACC_MULTIPLY_SUB, AMDU_OP_DPS: begin
        acc_sum = {acc_cur[AMDU_ACC_W-1], acc_cur} - {tail.term[AMDU_ACC_W-1], tail.term};
        next_acc = acc_sum[AMDU_ACC_W-1:0];
        acc_wr = tail.valid;
      end
      // accumulator shift, positive right and negative left
      AMDU_OP_SHILO: begin
        next_acc = tail.shamt[5] ? (acc_cur << shift_left) : (acc_cur >> tail.shamt);
        acc_wr = tail.valid;
      end
      default: begin
        next_acc = acc_cur;
        acc_wr = 1'b0;
      end
    endcase
    // saturating dot product clamps on signed overflow
    if (tail.saturate && ((tail.op == AMDU_OP_DPA) || (tail.op == AMDU_OP_DPS))
        && (acc_sum[AMDU_ACC_W] != acc_sum[AMDU_ACC_W-1])) begin
      next_acc = acc_sum[AMDU_ACC_W] ? AMDU_SAT_MIN : AMDU_SAT_MAX;
    end
  end

  // four pairs, each result except the register-bound ones written to the selected one
  // divide leaves remainder high, quotient low
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < AMDU_PAIRS; i++) begin
        acc[i] <= '0;
      end
    end else if (div_done) begin
      acc[div_acc_sel] <= {div_rem, div_quot};
    end else if (acc_wr) begin
      // pair updated five clocks after issue
      acc[tail.acc_sel] <= next_acc;
    end
  end

  // Divide destination pair held for the whole divide
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_acc_sel <= '0;
    end else if (div_start) begin
      div_acc_sel <= req_in.acc_sel;
    end
  end

  // General register write-back, registered at commit
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      res_out <= '0;
    end else begin
      res_out.valid <= 1'b0;
      res_out.dest <= tail.dest;
      case (tail.op)
        // low product straight to a register
        AMDU_OP_MUL_GENERAL_REGISTER: begin
          res_out.valid <= tail.valid;
          res_out.data <= tail.term[AMDU_W-1:0];
        end
        AMDU_OP_MOVE_FROM_HIGH: begin
          res_out.valid <= tail.valid;
          res_out.data <= acc_cur[AMDU_ACC_W-1:AMDU_W];
        end
        AMDU_OP_MOVE_FROM_LOW: begin
          res_out.valid <= tail.valid;
          res_out.data <= acc_cur[AMDU_W-1:0];
        end
        default: begin
          res_out.data <= res_out.data;
        end
      endcase
    end
  end

  // Iterative divider; its busy flag drives the issue stall
  amdu_divider u_divider (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .start_in(div_start),
    .signed_in(req_in.is_signed),
    .dividend_in(req_in.first_source_operand),
    .divisor_in(req_in.second_source_operand),
    .busy_out(div_busy),
    .done_out(div_done),
    .quot_out(div_quot),
    .rem_out(div_rem)
  );

endmodule

/* File: rtl/amdu_pkg.sv */
// Shared types and constants for the multiply/divide unit
// Functional notes
// - Own pipeline never stalls with integer pipeline
// - 32x32 multiplier, first operand times second operand
// - Four accumulator pairs; every result except the register-bound ones lands in one
// - New multiply accepted every clock, pipelined
// - Divide resolves one quotient bit per clock
// - Early-in skips 23/15/7 iterations by dividend width
// - Busy divide stalls further issue until done
// - Multiply family results 5 clocks after issue
// - Divide latency 12/20/28/36, signed +2 clocks
// - Move high or low half to register
// - Register multiply writes low product to register
// - Multiply-add adds, multiply-sub subtracts from pair
// - Accumulator shift and signal-processing multiplies
// - Dot-product forms, saturating or not, 5 clocks
// - Divide latency spans 12 to 38 clocks
package amdu_pkg;

  // Data path sizes
  localparam int AMDU_W = 32;
  localparam int AMDU_ACC_W = 64;
  localparam int AMDU_PAIRS = 4;
  localparam int AMDU_PAIR_W = 2;
  localparam int AMDU_REG_W = 5;

  // Multiply pipeline depth, in clocks from issue to commit
  localparam int AMDU_MUL_LAT = 5;

  // Divide early-in skip counts and starting iteration counts
  localparam logic [4:0] AMDU_SKIP_8 = 5'h17;
  localparam logic [4:0] AMDU_SKIP_16 = 5'h0f;
  localparam logic [4:0] AMDU_SKIP_24 = 5'h07;
  localparam logic [4:0] AMDU_SKIP_32 = 5'h00;
  localparam logic [5:0] AMDU_DIV_BITS = 6'h20;

  // Divide latencies, unsigned and signed, per dividend width
  localparam logic [5:0] AMDU_LAT_U8 = 6'h0c;
  localparam logic [5:0] AMDU_LAT_U16 = 6'h14;
  localparam logic [5:0] AMDU_LAT_U24 = 6'h1c;
  localparam logic [5:0] AMDU_LAT_U32 = 6'h24;
  localparam logic [5:0] AMDU_SIGN_EXTRA = 6'h02;

  // Saturation bounds for accumulating dot products
  localparam logic [63:0] AMDU_SAT_MAX = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] AMDU_SAT_MIN = 64'h8000_0000_0000_0000;

  // Operation codes issued by the integer pipeline
  typedef enum logic [3:0] {
    AMDU_OP_NONE = 4'h0,
    AMDU_OP_ACC_MULTIPLY = 4'h1,
    AMDU_OP_ACC_MULTIPLY_ADD = 4'h2,
    AMDU_OP_ACC_MULTIPLY_SUB = 4'h3,
    AMDU_OP_MUL_GENERAL_REGISTER = 4'h4,
    AMDU_OP_ITERATIVE_DIVIDE = 4'h5,
    AMDU_OP_MOVE_FROM_HIGH = 4'h6,
    AMDU_OP_MOVE_FROM_LOW = 4'h7,
    AMDU_OP_DPA = 4'h8,
    AMDU_OP_DPS = 4'h9,
    AMDU_OP_DMUL = 4'ha,
    AMDU_OP_SHILO = 4'hb
  } amdu_op_e;

  // One issued operation with its operands
  typedef struct packed {
    amdu_op_e op;
    logic is_signed;
    logic saturate;
    logic [AMDU_PAIR_W-1:0] acc_sel;
    logic [AMDU_REG_W-1:0] dest;
    logic [AMDU_W-1:0] first_source_operand;
    logic [AMDU_W-1:0] second_source_operand;
  } amdu_req_s;

  // One in-flight entry of the multiply pipeline
  typedef struct packed {
    logic valid;
    amdu_op_e op;
    logic saturate;
    logic [AMDU_PAIR_W-1:0] acc_sel;
    logic [AMDU_REG_W-1:0] dest;
    logic [5:0] shamt;
    logic [AMDU_ACC_W-1:0] term;
  } amdu_stage_s;

  // Write back to a general register
  typedef struct packed {
    logic valid;
    logic [AMDU_REG_W-1:0] dest;
    logic [AMDU_W-1:0] data;
  } amdu_res_s;

endpackage

/* File: rtl/amdu_divider.sv */
// Iterative early-in divider, one quotient bit per clock
`timescale 1ns/1ps
module amdu_divider
  import amdu_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic signed_in,
  input wire logic [AMDU_W-1:0] dividend_in,
  input wire logic [AMDU_W-1:0] divisor_in,
  output logic busy_out,
  output logic done_out,
  output logic [AMDU_W-1:0] quot_out,
  output logic [AMDU_W-1:0] rem_out
);

  typedef enum logic [0:0] {
    AMDU_DV_IDLE = 1'b0,
    AMDU_DV_RUN = 1'b1
  } amdu_dv_state_e;

  amdu_dv_state_e state;
  logic [AMDU_W-1:0] work_q;
  logic [AMDU_W-1:0] work_r;
  logic [AMDU_W-1:0] work_b;
  logic [5:0] iter_cnt;
  logic [5:0] lat_cnt;
  logic neg_q;
  logic neg_r;
  logic [AMDU_W-1:0] abs_a;
  logic [AMDU_W-1:0] abs_b;
  logic [4:0] skip;
  logic [5:0] lat;
  logic [AMDU_W:0] trial;

  // Operand magnitudes and early-in width check on the dividend
  always_comb begin
    abs_a = (signed_in && dividend_in[AMDU_W-1]) ? (~dividend_in + 32'h1) : dividend_in;
    abs_b = (signed_in && divisor_in[AMDU_W-1]) ? (~divisor_in + 32'h1) : divisor_in;
    if (signed_in ? (&dividend_in[31:7] || ~|dividend_in[31:7]) : ~|dividend_in[31:8]) begin
      skip = AMDU_SKIP_8;
      lat = AMDU_LAT_U8;
    end else if (signed_in ? (&dividend_in[31:15] || ~|dividend_in[31:15])
                           : ~|dividend_in[31:16]) begin
      skip = AMDU_SKIP_16;
      lat = AMDU_LAT_U16;
    end else if (signed_in ? (&dividend_in[31:23] || ~|dividend_in[31:23])
                           : ~|dividend_in[31:24]) begin
      skip = AMDU_SKIP_24;
      lat = AMDU_LAT_U24;
    end else begin
      skip = AMDU_SKIP_32;
      lat = AMDU_LAT_U32;
    end
    // signed divide costs two extra clocks
    if (signed_in) begin
      lat = lat + AMDU_SIGN_EXTRA;
    end
  end

  // Restoring step: shift one dividend bit in, try the subtract
  assign trial = {work_r, work_q[AMDU_W-1]} - {1'b0, work_b};

  // Sequencer; the latency counter pads past the iterations so timing is fixed
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= AMDU_DV_IDLE;
      work_q <= '0;
      work_r <= '0;
      work_b <= '0;
      iter_cnt <= '0;
      lat_cnt <= '0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
      done_out <= 1'b0;
      quot_out <= '0;
      rem_out <= '0;
    end else begin
      done_out <= 1'b0;
      case (state)
        AMDU_DV_IDLE: begin
          if (start_in) begin
            // Narrow dividends start pre-shifted, skipping dead iterations
            work_q <= abs_a << skip;
            work_r <= '0;
            work_b <= abs_b;
            iter_cnt <= AMDU_DIV_BITS - {1'b0, skip};
            lat_cnt <= lat - 6'h1;
            neg_q <= signed_in & (dividend_in[AMDU_W-1] ^ divisor_in[AMDU_W-1]);
            neg_r <= signed_in & dividend_in[AMDU_W-1];
            state <= AMDU_DV_RUN;
          end
        end
        AMDU_DV_RUN: begin
          lat_cnt <= lat_cnt - 6'h1;
          if (iter_cnt != 6'h0) begin
            iter_cnt <= iter_cnt - 6'h1;
            work_r <= trial[AMDU_W] ? {work_r[AMDU_W-2:0], work_q[AMDU_W-1]}
                                    : trial[AMDU_W-1:0];
            work_q <= {work_q[AMDU_W-2:0], ~trial[AMDU_W]};
          end
          // finish exactly at the table latency
          if (lat_cnt == 6'h1) begin
            quot_out <= neg_q ? (~work_q + 32'h1) : work_q;
            rem_out <= neg_r ? (~work_r + 32'h1) : work_r;
            done_out <= 1'b1;
            state <= AMDU_DV_IDLE;
          end
        end
        default: begin
          state <= AMDU_DV_IDLE;
        end
      endcase
    end
  end

  assign busy_out = (state == AMDU_DV_RUN);

endmodule

/* File: bench/amdu_core_chk.sv */
// Port checker for the multiply/divide unit
`timescale 1ns/1ps
module amdu_core_chk
  import amdu_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic req_valid_in,
  input wire amdu_req_s req_in,
  input wire logic stall_out,
  input wire logic div_busy_out,
  input wire amdu_res_s res_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  logic take, take_reg, take_div, take_mul;
  logic [31:0] prod;
  logic [5:0] busy_cnt, exp_lat;

  function automatic logic fit(logic s, logic [31:0] d, int n);
    logic [31:0] h;
    h = s ? 32'($signed(d) >>> (n - 1)) : d >> n;
    return h == 32'h0 || &h;
  endfunction

  function automatic logic [5:0] lat_of(logic s, logic [31:0] d);
    logic [5:0] x;
    x = fit(s, d, 8) ? AMDU_LAT_U8 : fit(s, d, 16) ? AMDU_LAT_U16 :
        fit(s, d, 24) ? AMDU_LAT_U24 : AMDU_LAT_U32;
    return s ? x + AMDU_SIGN_EXTRA : x;
  endfunction

  // Issue decode as seen at the ports
  assign take = req_valid_in && !stall_out;
  assign take_div = take && req_in.op == AMDU_OP_ITERATIVE_DIVIDE;
  assign take_mul = take && req_in.op == AMDU_OP_MUL_GENERAL_REGISTER;
  assign take_reg = take_mul || (take && req_in.op inside {AMDU_OP_MOVE_FROM_HIGH,
                                                            AMDU_OP_MOVE_FROM_LOW});
  assign prod = 32'(req_in.first_source_operand * req_in.second_source_operand);

  // Expected span latched at issue, since the dividend is gone by the end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) exp_lat <= 6'h00;
    else if (take_div) exp_lat <= lat_of(req_in.is_signed, req_in.first_source_operand);
  end

  // Busy length; a stuck busy shows up as an overrun
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) busy_cnt <= 6'h00;
    else busy_cnt <= div_busy_out ? busy_cnt + 6'h01 : 6'h00;
  end

  sequence reg_commit;
    ##6 res_out.valid && res_out.data == $past(prod, 6) && res_out.dest == $past(req_in.dest, 6);
  endsequence

  a_stall_match: assert property (stall_out == (req_valid_in && div_busy_out))
    else $error("stall does not follow busy divide");
  a_reg_result: assert property (take_mul |-> reg_commit)
    else $error("register multiply result wrong or late");
  a_valid_cause: assert property (res_out.valid |-> $past(take_reg, 6))
    else $error("result without matching issue");
  a_busy_start: assert property (take_div |=> div_busy_out)
    else $error("divide taken but not busy");
  a_div_length: assert property ($fell(div_busy_out) |-> busy_cnt == exp_lat - 6'h01)
    else $error("divide span differs from dividend width");
  a_div_range: assert property ($fell(div_busy_out) |-> busy_cnt >= 6'h0b)
    else $error("divide too short");
  a_busy_bound: assert property (busy_cnt <= 6'h25)
    else $error("divide runs too long");
  a_mul_no_busy: assert property (take && !take_div |=> !div_busy_out)
    else $error("non-divide op started divider");
endmodule

bind amdu_core amdu_core_chk u_chk (.clock_in(clock_in), .nrst_in(nrst_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .stall_out(stall_out),
  .div_busy_out(div_busy_out), .res_out(res_out));

/* File: bench/amdu_issuer.sv */
// Integer pipeline model that issues operations to the unit
`timescale 1ns/1ps
module amdu_issuer
  import amdu_pkg::*;
(
  input wire logic clock_in,
  input wire logic stall_in,
  output logic req_valid_out,
  output amdu_req_s req_out
);
  int stalls;
  initial begin
    req_valid_out = 1'b0;
    req_out = '0;
  end

  task automatic issue(input amdu_req_s r);
    @(negedge clock_in);
    req_valid_out = 1'b1;
    req_out = r;
    stalls = 0;
    // Stall is read mid-cycle once settled, never in the step of the edge that moves it
    #1;
    while (stall_in && stalls < 60) begin
      stalls++;
      @(negedge clock_in);
      #1;
    end
    @(posedge clock_in);
  endtask

  // Released operands flip so stale values never look valid
  task automatic idle();
    @(negedge clock_in);
    req_valid_out = 1'b0;
    req_out = ~req_out;
  endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
module testbench
  import amdu_pkg::*;
;
  logic clock_in = 1'b0;
  logic nrst_in, stall_out, div_busy_out, req_valid;
  amdu_req_s req;
  amdu_res_s res_out;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] q[$];

  // Clock at 25 MHz
  always #20 clock_in = ~clock_in;

  amdu_issuer pipe (.clock_in(clock_in), .stall_in(stall_out), .req_valid_out(req_valid),
    .req_out(req));
  amdu_core dut (.clock_in(clock_in), .nrst_in(nrst_in), .req_valid_in(req_valid),
    .req_in(req), .stall_out(stall_out), .div_busy_out(div_busy_out), .res_out(res_out));

  // Collect register-bound results mid-cycle, while the one-cycle valid stands
  always @(negedge clock_in) begin
    if (res_out.valid === 1'b1) q.push_back(res_out.data);
  end

  // Cut a hang short
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic amdu_req_s mk(amdu_op_e op, logic s, logic [1:0] p, logic [31:0] a, b);
    return '{op: op, is_signed: s, saturate: 1'b0, acc_sel: p, dest: 5'h03,
      first_source_operand: a, second_source_operand: b};
  endfunction

  function automatic logic [63:0] dp(logic [31:0] a, logic [31:0] b);
    longint t;
    t = $signed(a[31:16]) * $signed(b[31:16]) + $signed(a[15:0]) * $signed(b[15:0]);
    return t;
  endfunction

  // Read a pair back through both moves, issued back to back
  task automatic rd_pair(input logic [1:0] p, output logic [63:0] v, output int st);
    q.delete();
    pipe.issue(mk(AMDU_OP_MOVE_FROM_LOW, 1'b0, p, 32'h0, 32'h0));
    st = pipe.stalls;
    pipe.issue(mk(AMDU_OP_MOVE_FROM_HIGH, 1'b0, p, 32'h0, 32'h0));
    pipe.idle();
    repeat (8) @(posedge clock_in);
    v = (q.size() == 2) ? {q[1], q[0]} : 64'hx;
  endtask

  task automatic t_gpr();
    logic [31:0] a[3] = '{32'hffff_fffd, 32'h0001_2345, 32'h8000_0001};
    logic [31:0] b[3] = '{32'h5, 32'h0000_ffff, 32'hffff_ffff};
    q.delete();
    for (int i = 0; i < 3; i++) begin
      pipe.issue(mk(AMDU_OP_MUL_GENERAL_REGISTER, 1'b1, 2'h0, a[i], b[i]));
    end
    pipe.idle();
    repeat (8) @(posedge clock_in);
    chk(64'(q.size()), 64'h3);
    for (int i = 0; i < 3; i++) begin
      chk({32'h0, q[i]}, {32'h0, 32'(a[i] * b[i])});
    end
  endtask

  task automatic t_acc();
    logic [63:0] v;
    int st;
    pipe.issue(mk(AMDU_OP_ACC_MULTIPLY, 1'b1, 2'h1, 32'hffff_fffd, 32'h5));
    pipe.issue(mk(AMDU_OP_ACC_MULTIPLY_ADD, 1'b1, 2'h1, 32'h7, 32'h9));
    pipe.issue(mk(AMDU_OP_ACC_MULTIPLY_SUB, 1'b0, 2'h1, 32'hffff_ffff, 32'h2));
    pipe.issue(mk(AMDU_OP_ACC_MULTIPLY, 1'b0, 2'h2, 32'hffff_ffff, 32'hffff_ffff));
    rd_pair(2'h1, v, st);
    chk(v, 64'h30 - 64'h1_ffff_fffe);
    rd_pair(2'h2, v, st);
    chk(v, 64'hffff_fffe_0000_0001);
  endtask

  task automatic t_dsp();
    logic [63:0] e, v;
    int st;
    e = dp(32'h7fff_8000, 32'h7fff_8000) + dp(32'hfffe_0003, 32'h0004_0005);
    e = ((e - dp(32'h0002_0002, 32'h0003_0003)) << 4) >> 8;
    pipe.issue(mk(AMDU_OP_DMUL, 1'b1, 2'h0, 32'h7fff_8000, 32'h7fff_8000));
    pipe.issue(mk(AMDU_OP_DPA, 1'b1, 2'h0, 32'hfffe_0003, 32'h0004_0005));
    pipe.issue(mk(AMDU_OP_DPS, 1'b1, 2'h0, 32'h0002_0002, 32'h0003_0003));
    pipe.issue(mk(AMDU_OP_SHILO, 1'b1, 2'h0, 32'h0, 32'hffff_fffc));
    pipe.issue(mk(AMDU_OP_SHILO, 1'b1, 2'h0, 32'h0, 32'h8));
    rd_pair(2'h0, v, st);
    chk(v, e);
  endtask

  // Saturating dot products clamp at both ends; the plain one wraps in between
  task automatic t_sat();
    amdu_req_s r;
    logic [63:0] v;
    int st;
    pipe.issue(mk(AMDU_OP_ACC_MULTIPLY, 1'b0, 2'h2, 32'h1, 32'h1));
    pipe.issue(mk(AMDU_OP_SHILO, 1'b1, 2'h2, 32'h0, 32'hffff_ffe0));
    pipe.issue(mk(AMDU_OP_SHILO, 1'b1, 2'h2, 32'h0, 32'hffff_ffe1));
    r = mk(AMDU_OP_DPS, 1'b1, 2'h2, 32'hfffe_0003, 32'h0004_0005);
    r.saturate = 1'b1;
    pipe.issue(r);
    rd_pair(2'h2, v, st);
    chk(v, AMDU_SAT_MIN);
    pipe.issue(mk(AMDU_OP_DPS, 1'b1, 2'h2, 32'hfffe_0003, 32'h0004_0005));
    r.op = AMDU_OP_DPA;
    pipe.issue(r);
    rd_pair(2'h2, v, st);
    chk(v, AMDU_SAT_MAX);
  endtask

  // A multiply issued just ahead of a divide finishes while the issuer is held
  task automatic t_overlap();
    q.delete();
    pipe.issue(mk(AMDU_OP_MUL_GENERAL_REGISTER, 1'b0, 2'h0, 32'h10, 32'h20));
    pipe.issue(mk(AMDU_OP_ITERATIVE_DIVIDE, 1'b0, 2'h3, 32'h64, 32'h7));
    pipe.issue(mk(AMDU_OP_MOVE_FROM_LOW, 1'b0, 2'h3, 32'h0, 32'h0));
    chk(64'(pipe.stalls), 64'(AMDU_LAT_U8 - 6'h01));
    chk(64'(q.size()), 64'h1);
    chk({32'h0, q[0]}, 64'h200);
    pipe.idle();
    repeat (8) @(posedge clock_in);
    chk(64'(q.size()), 64'h2);
    chk({32'h0, q[1]}, 64'he);
  endtask

  task automatic t_div();
    logic [31:0] d[8] = '{32'h64, 32'hbeef, 32'h12_3456, 32'hf000_0000,
      32'hffff_ff80, 32'hffff_8000, 32'h007f_ffff, 32'h8000_0000};
    logic [31:0] dv[8] = '{32'h7, 32'h5, 32'h9, 32'h3, 32'h3, 32'hffff_fffb, 32'h3, 32'h7};
    int lat[8] = '{12, 20, 28, 36, 14, 22, 30, 38};
    logic [31:0] qt, rm;
    logic [63:0] v;
    int st;
    for (int i = 0; i < 8; i++) begin
      if (i > 3) begin
        qt = $signed(d[i]) / $signed(dv[i]);
        rm = $signed(d[i]) % $signed(dv[i]);
      end else begin
        qt = d[i] / dv[i];
        rm = d[i] % dv[i];
      end
      pipe.issue(mk(AMDU_OP_ITERATIVE_DIVIDE, i > 3, 2'h3, d[i], dv[i]));
      rd_pair(2'h3, v, st);
      chk(64'(st), 64'(lat[i] - 1));
      chk(v, {rm, qt});
    end
  endtask

  // Reset, then run every scenario
  initial begin
    nrst_in = 1'b0;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    nrst_in = 1'b1;
    t_gpr();
    t_acc();
    t_dsp();
    t_sat();
    t_overlap();
    t_div();
    wrap_up();
  end
endmodule
